// >>> hdl/bhpa_core.sv
`timescale 1ns/1ps
`default_nettype none
module bhpa_core
   import bhpa_pkg::*;
#(
   parameter int unsigned PF_DEPTH = PFQ_DEPTH,
   parameter int unsigned MOV_LAT  = MOV_LAT_CYC
)(
   input  wire logic            clk,
   input  wire logic            reset,
   input  wire bhpa_branch_type br,
   input  wire bhpa_brp_type    brp0,
   input  wire bhpa_brp_type    brp1,
   input  wire logic            mov_valid,
   input  wire bhpa_whether_type mov_whether,
   input  wire logic            mov_imp,
   input  wire logic [31:0]     mov_bundle_addr,
   input  wire logic [31:0]     mov_target,
   input  wire logic [7:0]      epilogue_count,
   input  wire logic            dir_hit,
   input  wire logic            mispredict_flush,
   output logic                 dir_alloc,
   output logic                 dir_update,
   output logic                 dir_multiway,
   output logic                 static_pred,
   output logic                 force_taken,
   output logic                 tac_wr_valid,
   output bhpa_tac_wr_type      tac_wr,
   output logic                 tar_wr_valid,
   output bhpa_tac_wr_type      tar_wr,
   output logic                 ret_push,
   output logic                 ret_pop,
   output logic                 loop_exit_armed,
   output logic                 loop_exit_predict,
   output logic                 pf_full,
   output logic                 pf_dropped,
   output logic                 pf_busy,
   output logic                 pf_cache_valid,
   output logic [31:0]          pf_cache_addr,
   input  wire logic            pf_cache_ready
);
   ////////////////////////////////////////////////////////////////////////////
   // Branch completers

   logic br_static;
   logic br_tk;
   logic br_multi;
   logic dir_alloc_d;
   logic tac_br_d;

   assign br_static = (br.whether == BHPA_SPNT) || (br.whether == BHPA_SPTK);
   assign br_tk     = (br.whether == BHPA_SPTK) || (br.whether == BHPA_DPTK);
   // Bundle type is not carried; a non-third slot implies a multiway bundle
   assign br_multi  = (br.slot != BRP_SLOT);

   always_comb
   begin
      dir_alloc_d = 1'b0;
      tac_br_d    = 1'b0;
      if (br.valid && !br.clr)
      begin
         if (br_static)
         begin
            dir_alloc_d = (br.whether == BHPA_SPTK) && (br.is_call || br.is_ret);
            tac_br_d    = (br.whether == BHPA_SPTK) && !br.is_ret;
         end
         else
         begin
            dir_alloc_d = (!dir_hit && br.mispredicted)
                          || (br.taken && (br.is_call || br.is_ret));
            tac_br_d    = br.taken && !br.is_ret;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         dir_alloc    <= 1'b0;
         dir_update   <= 1'b0;
         dir_multiway <= 1'b0;
         static_pred  <= 1'b0;
         force_taken  <= 1'b0;
      end
      else
      begin
         dir_alloc    <= dir_alloc_d;
         dir_update   <= br.valid && !br.clr && dir_hit;
         dir_multiway <= br_multi;
         static_pred  <= br_tk;
         force_taken  <= br.valid && (br.whether == BHPA_SPTK)
                         && (br.is_call || br.is_ret);
      end
   end

   // Return stack follows calls and returns even under deallocate
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ret_push <= 1'b0;
         ret_pop  <= 1'b0;
      end
      else
      begin
         ret_push <= br.valid && br.is_call && br.taken;
         ret_pop  <= br.valid && br.is_ret && br.taken;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Branch-predict hints

   function automatic logic brp_act(input bhpa_brp_type h);
      begin
         brp_act = h.valid && (h.slot == BRP_SLOT)
                   && ((h.kind == BHPA_BRP_SPTK) || (h.kind == BHPA_BRP_DPTK)
                       || (h.kind == BHPA_BRP_LOOP));
      end
   endfunction

   logic brp0_act;
   logic brp1_act;
   assign brp0_act = brp_act(brp0);
   assign brp1_act = brp_act(brp1);

   ////////////////////////////////////////////////////////////////////////////
   // Move-to-branch delay line: the hint becomes visible MOV_LAT cycles later

   logic            mov_tk;
   logic [MOV_LAT-1:0] mov_v_q;
   logic [MOV_LAT-1:0] mov_imp_q;
   bhpa_tac_wr_type    mov_q [MOV_LAT];

   assign mov_tk = mov_valid && ((mov_whether == BHPA_SPTK) || (mov_whether == BHPA_DPTK));

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         mov_v_q   <= '0;
         mov_imp_q <= '0;
      end
      else
      begin
         mov_v_q   <= {mov_v_q[MOV_LAT-2:0], mov_tk};
         mov_imp_q <= {mov_imp_q[MOV_LAT-2:0], mov_imp};
      end
   end

   always_ff @(posedge clk)
   begin
      mov_q[0] <= '{bundle_addr: mov_bundle_addr, target: mov_target, slot: TAC_SLOT_BRP};
      for (int i = 1; i < MOV_LAT; i++)
         mov_q[i] <= mov_q[i-1];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Target cache and target register write port, one write per cycle.
   // Branch outcome wins, then hints; losers are dropped as hints may be.

   logic mov_out;
   assign mov_out = mov_v_q[MOV_LAT-1];

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         tac_wr_valid <= 1'b0;
         tac_wr       <= '0;
      end
      else
      begin
         tac_wr_valid <= tac_br_d || brp0_act || brp1_act || mov_out;
         if (tac_br_d)
            tac_wr <= '{bundle_addr: br.bundle_addr, target: br.target, slot: br.slot};
         else if (brp0_act)
            tac_wr <= '{bundle_addr: brp0.bundle_addr, target: brp0.target,
                        slot: TAC_SLOT_BRP};
         else if (brp1_act)
            tac_wr <= '{bundle_addr: brp1.bundle_addr, target: brp1.target,
                        slot: TAC_SLOT_BRP};
         else if (mov_out)
            tac_wr <= mov_q[MOV_LAT-1];
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         tar_wr_valid <= 1'b0;
         tar_wr       <= '0;
      end
      else
      begin
         tar_wr_valid <= (brp0_act && brp0.imp) || (brp1_act && brp1.imp)
                         || (mov_out && mov_imp_q[MOV_LAT-1]);
         if (brp0_act && brp0.imp)
            tar_wr <= '{bundle_addr: brp0.bundle_addr, target: brp0.target, slot: TAC_SLOT_BRP};
         else if (brp1_act && brp1.imp)
            tar_wr <= '{bundle_addr: brp1.bundle_addr, target: brp1.target, slot: TAC_SLOT_BRP};
         else if (mov_out)
            tar_wr <= mov_q[MOV_LAT-1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Loop exit predictor; short loops in flight may still miss the last exit

   always_ff @(posedge clk)
   begin
      if (reset)
         loop_exit_armed <= 1'b0;
      else if ((brp0_act && brp0.imp && brp0.kind == BHPA_BRP_LOOP)
               || (brp1_act && brp1.imp && brp1.kind == BHPA_BRP_LOOP))
         loop_exit_armed <= 1'b1;
      else if (br.valid && (br.is_cloop || br.is_ctop) && !br.taken)
         loop_exit_armed <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         loop_exit_predict <= 1'b0;
      else
         loop_exit_predict <= loop_exit_armed && br.valid
                              && (br.is_ctop
                                  || (br.is_cloop && epilogue_count == EC_LOOP_VAL));
   end

   ////////////////////////////////////////////////////////////////////////////
   // Prefetch requests, one accepted per clock

   logic            pf_in_valid;
   bhpa_pf_req_type pf_in;
   logic            q_valid;
   bhpa_pf_req_type q_req;
   logic            eng_ready;
   logic            br_stream;

   assign br_stream = br.valid && br.predicted_taken && (br.pf == BHPA_PF_MANY)
                      && (br.slot == BRP_SLOT);

   always_comb
   begin
      pf_in_valid = 1'b0;
      pf_in       = '0;
      if (br_stream)
      begin
         pf_in_valid = 1'b1;
         pf_in.stream = 1'b1;
         pf_in.addr   = (br.target & ~32'(L2_LINE_B - 1)) + 32'(L2_LINE_B);
      end
      else if (brp0.valid && brp0.slot == BRP_SLOT && brp0.line_pf)
      begin
         pf_in_valid = 1'b1;
         pf_in.addr  = brp0.target;
      end
      else if (brp1.valid && brp1.slot == BRP_SLOT && brp1.line_pf)
      begin
         pf_in_valid = 1'b1;
         pf_in.addr  = brp1.target;
      end
   end

   bhpa_pf_queue #(.DEPTH(PF_DEPTH)) u_queue (
      .clk       (clk),
      .reset     (reset),
      .flush     (mispredict_flush),
      .in_valid  (pf_in_valid),
      .in_req    (pf_in),
      .full      (pf_full),
      .dropped   (pf_dropped),
      .out_valid (q_valid),
      .out_req   (q_req),
      .out_ready (eng_ready)
   );

   bhpa_stream_pf u_stream (
      .clk         (clk),
      .reset       (reset),
      .req_valid   (q_valid),
      .req         (q_req),
      .req_ready   (eng_ready),
      .stop        (br.valid && br.predicted_taken),
      .busy        (pf_busy),
      .cache_valid (pf_cache_valid),
      .cache_addr  (pf_cache_addr),
      .cache_ready (pf_cache_ready)
   );
endmodule
`default_nettype wire

// >>> hdl/bhpa_pkg.sv
package bhpa_pkg;

   localparam int unsigned ADDR_W        = 32;
   localparam int unsigned SLOT_W        = 2;
   localparam logic [1:0]  BRP_SLOT      = 2'h2;   // Third slot, counted from zero
   localparam logic [1:0]  TAC_SLOT_BRP  = 2'h3;   // Slot field written for hint writes
   localparam int unsigned BRP_FETCHES   = 4;
   localparam int unsigned IMP_FETCHES   = 5;
   localparam int unsigned BUNDLES_FETCH = 2;
   localparam int unsigned MOV_LAT_NS    = 225;
   localparam int unsigned CLK_NS        = 25;
   localparam int unsigned MOV_LAT_CYC   = (MOV_LAT_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned MOV_FETCH_MIN = 9;
   localparam int unsigned MOV_FETCH_MAX = 13;
   localparam logic [7:0]  EC_LOOP_VAL   = 8'h01;
   localparam int unsigned LINE_PF_LINES = 2;
   localparam int unsigned PFQ_DEPTH     = 4;
   localparam int unsigned L1_LINE_B     = 32;
   localparam int unsigned L2_LINE_B     = 64;

   typedef enum logic [1:0] {
      BHPA_SPNT = 2'h0,
      BHPA_SPTK = 2'h1,
      BHPA_DPNT = 2'h2,
      BHPA_DPTK = 2'h3
   } bhpa_whether_type;

   typedef enum logic [1:0] {
      BHPA_PF_NONE = 2'h0,
      BHPA_PF_FEW  = 2'h1,
      BHPA_PF_MANY = 2'h2
   } bhpa_pf_hint_type;

   typedef enum logic [2:0] {
      BHPA_BRP_SPTK = 3'h0,
      BHPA_BRP_DPTK = 3'h1,
      BHPA_BRP_LOOP = 3'h2,
      BHPA_BRP_EXIT = 3'h3,
      BHPA_BRP_RET  = 3'h4,
      BHPA_BRP_IND  = 3'h5
   } bhpa_brp_kind_type;

   typedef struct packed {
      logic             valid;
      logic [1:0]       slot;
      logic [31:0]      bundle_addr;
      logic [31:0]      target;
      bhpa_whether_type whether;
      bhpa_pf_hint_type pf;
      logic             clr;
      logic             is_call;
      logic             is_ret;
      logic             is_cloop;
      logic             is_ctop;
      logic             taken;
      logic             predicted_taken;
      logic             mispredicted;
   } bhpa_branch_type;

   typedef struct packed {
      logic              valid;
      logic [1:0]        slot;
      logic [31:0]       bundle_addr;
      logic [31:0]       target;
      bhpa_brp_kind_type kind;
      logic              imp;
      logic              line_pf;
   } bhpa_brp_type;

   typedef struct packed {
      logic [31:0] bundle_addr;
      logic [31:0] target;
      logic [1:0]  slot;
   } bhpa_tac_wr_type;

   typedef struct packed {
      logic        stream;
      logic [31:0] addr;
   } bhpa_pf_req_type;

endpackage

// >>> hdl/bhpa_pf_queue.sv
`timescale 1ns/1ps
`default_nettype none
module bhpa_pf_queue
   import bhpa_pkg::*;
#(
   parameter int unsigned DEPTH = PFQ_DEPTH
)(
   input  wire logic            clk,
   input  wire logic            reset,
   input  wire logic            flush,
   input  wire logic            in_valid,
   input  wire bhpa_pf_req_type in_req,
   output logic                 full,
   output logic                 dropped,
   output logic                 out_valid,
   output bhpa_pf_req_type      out_req,
   input  wire logic            out_ready
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   bhpa_pf_req_type  mem_q [DEPTH];
   logic [AW-1:0]    rd_q;
   logic [AW-1:0]    wr_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign full      = (cnt_q == (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign pop       = out_valid && out_ready;
   assign push      = in_valid && !full && !flush;
   assign out_req   = mem_q[rd_q];

   // Full queue discards the arrival rather than stalling issue
   always_ff @(posedge clk)
   begin
      if (reset)
         dropped <= 1'b0;
      else
         dropped <= in_valid && full && !flush;
   end

   always_ff @(posedge clk)
   begin
      if (push)
         mem_q[wr_q] <= in_req;
   end

   always_ff @(posedge clk)
   begin
      if (reset || flush)
      begin
         rd_q  <= '0;
         wr_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (pop)
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         if (push && !pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop && !push)
            cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/bhpa_stream_pf.sv
`timescale 1ns/1ps
`default_nettype none
module bhpa_stream_pf
   import bhpa_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            reset,
   input  wire logic            req_valid,
   input  wire bhpa_pf_req_type req,
   output logic                 req_ready,
   input  wire logic            stop,
   output logic                 busy,
   output logic                 cache_valid,
   output logic [31:0]          cache_addr,
   input  wire logic            cache_ready
);
   typedef enum logic [2:0] {
      SP_IDLE   = 3'b001,
      SP_LINE   = 3'b010,
      SP_STREAM = 3'b100
   } bhpa_sp_state_type;

   bhpa_sp_state_type state_q;
   logic [31:0]       addr_q;
   logic [1:0]        left_q;

   assign busy        = (state_q != SP_IDLE);
   assign req_ready   = (state_q == SP_IDLE);
   assign cache_valid = busy;
   assign cache_addr  = addr_q;

   // Stream engine runs on its own, only a predicted-taken branch stops it
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_q <= SP_IDLE;
         addr_q  <= '0;
         left_q  <= '0;
      end
      else
      begin
         case (state_q)
            SP_IDLE:
               if (req_valid)
               begin
                  addr_q  <= req.addr;
                  left_q  <= 2'(LINE_PF_LINES);
                  state_q <= req.stream ? SP_STREAM : SP_LINE;
               end
            SP_LINE:
               if (cache_ready)
               begin
                  addr_q <= addr_q + 32'(L1_LINE_B);
                  left_q <= left_q - 1'b1;
                  if (left_q == 2'h1)
                     state_q <= SP_IDLE;
               end
            SP_STREAM:
               if (stop)
                  state_q <= SP_IDLE;
               else if (cache_ready)
                  addr_q <= addr_q + 32'(L1_LINE_B);
            default:
               state_q <= SP_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> verification/bhpa_icache_model.sv
`timescale 1ns/1ps
`default_nettype none
module bhpa_icache_model
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        stall,
   input  wire logic        req_valid,
   input  wire logic [31:0] req_addr,
   output logic             ready,
   output logic [31:0]      last_addr,
   output int               n_got
);
   // Stall holds ready low so the engine must keep its request standing
   assign ready = req_valid && !stall;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         n_got <= 0;
         last_addr <= 32'h0000_0000;
      end
      else if (req_valid && ready)
      begin
         n_got <= n_got + 1;
         last_addr <= req_addr;
      end
   end
endmodule
`default_nettype wire

// >>> verification/bhpa_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bhpa_core_chk
   import bhpa_pkg::*;
(
   input wire logic            clk,
   input wire logic            reset,
   input wire bhpa_branch_type br,
   input wire bhpa_brp_type    brp0,
   input wire bhpa_brp_type    brp1,
   input wire logic [7:0]      epilogue_count,
   input wire logic            mispredict_flush,
   input wire logic            dir_alloc,
   input wire logic            dir_update,
   input wire logic            tac_wr_valid,
   input wire bhpa_tac_wr_type tac_wr,
   input wire logic            ret_push,
   input wire logic            loop_exit_armed,
   input wire logic            loop_exit_predict,
   input wire logic            pf_full,
   input wire logic            pf_dropped,
   input wire logic            pf_busy,
   input wire logic            pf_cache_valid,
   input wire logic [31:0]     pf_cache_addr,
   input wire logic            pf_cache_ready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   spnt_no_alloc_a: assert property (br.valid && br.whether == BHPA_SPNT && !br.is_call
      && !br.is_ret |=> !dir_alloc) else $error("static branch allocated direction entry");
   sptk_tac_a: assert property (br.valid && br.whether == BHPA_SPTK && !br.clr && !br.is_ret
      && !br.taken |=> tac_wr_valid && tac_wr.target == $past(br.target))
      else $error("static taken branch missed target write");
   clr_no_alloc_a: assert property (br.valid && br.clr |=> !dir_alloc && !dir_update)
      else $error("deallocate branch touched direction table");
   call_push_a: assert property (br.valid && br.is_call && br.taken |=> ret_push)
      else $error("taken call did not push");
   brp_slot_a: assert property (brp0.valid && brp0.slot == BRP_SLOT
      && brp0.kind == BHPA_BRP_LOOP && !br.valid |=> tac_wr_valid && tac_wr.slot == TAC_SLOT_BRP)
      else $error("hint target write wrong");
   brp_ret_nop_a: assert property (brp0.valid && brp0.kind == BHPA_BRP_RET && !brp1.valid
      |=> !$rose(loop_exit_armed)) else $error("return hint had an effect");
   loop_arm_a: assert property (brp0.valid && brp0.slot == BRP_SLOT && brp0.imp
      && brp0.kind == BHPA_BRP_LOOP && !br.valid |=> loop_exit_armed) else $error("loop not armed");
   ctop_exit_a: assert property (loop_exit_armed && br.valid && br.is_ctop
      |=> loop_exit_predict) else $error("modulo loop exit not predicted");
   cloop_ec_a: assert property (loop_exit_armed && br.valid && br.is_cloop && !br.is_ctop
      && epilogue_count != EC_LOOP_VAL |=> !loop_exit_predict) else $error("exit without count one");
   pf_hold_a: assert property (pf_cache_valid && !pf_cache_ready && !mispredict_flush
      && !(br.valid && br.predicted_taken) |=> pf_cache_valid && $stable(pf_cache_addr))
      else $error("prefetch request withdrawn");
   pf_drop_a: assert property (pf_busy && pf_full && !pf_cache_ready && brp0.valid
      && brp0.line_pf && brp0.slot == BRP_SLOT && !br.valid && !mispredict_flush |=> pf_dropped)
      else $error("full queue did not drop");
endmodule

bind bhpa_core bhpa_core_chk bhpa_core_chk_i (.clk(clk), .reset(reset), .br(br), .brp0(brp0),
   .brp1(brp1), .epilogue_count(epilogue_count), .mispredict_flush(mispredict_flush),
   .dir_alloc(dir_alloc), .dir_update(dir_update), .tac_wr_valid(tac_wr_valid), .tac_wr(tac_wr),
   .ret_push(ret_push), .loop_exit_armed(loop_exit_armed), .loop_exit_predict(loop_exit_predict),
   .pf_full(pf_full), .pf_dropped(pf_dropped), .pf_busy(pf_busy), .pf_cache_valid(pf_cache_valid),
   .pf_cache_addr(pf_cache_addr), .pf_cache_ready(pf_cache_ready));
`default_nettype wire

// >>> verification/tb_bhpa_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bhpa_core;
   import bhpa_pkg::*;
   localparam int MOV_L = 9;
   logic             clk;
   logic             reset;
   bhpa_branch_type  br;
   bhpa_branch_type  b;
   bhpa_brp_type     brp0;
   bhpa_brp_type     brp1;
   logic             mov_valid;
   bhpa_whether_type mov_whether;
   logic             mov_imp;
   logic [7:0]       epilogue_count;
   logic             dir_hit;
   logic             mispredict_flush;
   logic             stall;
   logic             dir_alloc, dir_update, dir_multiway, static_pred, force_taken;
   logic             tac_wr_valid, tar_wr_valid, ret_push, ret_pop, loop_exit_armed;
   logic             loop_exit_predict, pf_full, pf_dropped, pf_busy, pf_cache_valid;
   logic             pf_cache_ready;
   bhpa_tac_wr_type  tac_wr;
   bhpa_tac_wr_type  tar_wr;
   logic [31:0]      pf_cache_addr;
   logic [31:0]      last_addr;
   int               n_got, fails, n_checks, k, n0, drops;

   bhpa_core #(.PF_DEPTH(2), .MOV_LAT(MOV_L)) bhpa_core_i (.clk(clk), .reset(reset), .br(br),
      .brp0(brp0), .brp1(brp1), .mov_valid(mov_valid), .mov_whether(mov_whether),
      .mov_imp(mov_imp), .mov_bundle_addr(32'h0000_6000), .mov_target(32'h0000_7000),
      .epilogue_count(epilogue_count), .dir_hit(dir_hit), .mispredict_flush(mispredict_flush),
      .dir_alloc(dir_alloc), .dir_update(dir_update), .dir_multiway(dir_multiway),
      .static_pred(static_pred), .force_taken(force_taken), .tac_wr_valid(tac_wr_valid),
      .tac_wr(tac_wr), .tar_wr_valid(tar_wr_valid), .tar_wr(tar_wr), .ret_push(ret_push),
      .ret_pop(ret_pop), .loop_exit_armed(loop_exit_armed), .loop_exit_predict(loop_exit_predict),
      .pf_full(pf_full), .pf_dropped(pf_dropped), .pf_busy(pf_busy),
      .pf_cache_valid(pf_cache_valid), .pf_cache_addr(pf_cache_addr),
      .pf_cache_ready(pf_cache_ready));
   bhpa_icache_model bhpa_icache_model_i (.clk(clk), .reset(reset), .stall(stall),
      .req_valid(pf_cache_valid), .req_addr(pf_cache_addr), .ready(pf_cache_ready),
      .last_addr(last_addr), .n_got(n_got));

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic check(input logic [71:0] seen, input logic [71:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // All drives land 1 ns after the edge, so outputs are settled when read
   task automatic step();
      @(posedge clk);
      #1;
   endtask

   task automatic fire_br(input bhpa_branch_type x);
      br = x;
      step();
      br = '0;
   endtask

   task automatic wait_got(input int n);
      for (k = 0; k < 60 && n_got < n; k++)
         step();
      if (n_got < n)
      begin
         fails++;
         report_and_stop();
      end
   endtask

   function automatic bhpa_branch_type mkb(input bhpa_whether_type w, input logic [4:0] f);
      bhpa_branch_type x;
      x = '0;
      x.valid = 1'b1;
      x.slot = BRP_SLOT;
      x.bundle_addr = 32'h0000_1000;
      x.target = 32'h0000_2010;
      x.whether = w;
      {x.is_call, x.is_ret, x.taken, x.predicted_taken, x.mispredicted} = f;
      return x;
   endfunction

   function automatic bhpa_brp_type mkp(input bhpa_brp_kind_type kd, input logic [31:0] t);
      bhpa_brp_type p;
      p = '0;
      p.valid = 1'b1;
      p.slot = BRP_SLOT;
      p.bundle_addr = 32'h0000_3000;
      p.target = t;
      p.kind = kd;
      return p;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      report_and_stop();
   end

   initial
   begin
      {br, brp0, brp1, mov_valid, mov_imp, dir_hit, mispredict_flush, stall} = '0;
      mov_whether = BHPA_SPNT;
      epilogue_count = 8'h00;
      reset = 1'b1;
      repeat (12) @(posedge clk);
      #1;
      reset = 1'b0;
      fire_br(mkb(BHPA_DPTK, 5'b00110));
      check({dir_alloc, tac_wr_valid, tac_wr}, {2'b01, 32'h0000_1000, 32'h0000_2010, 2'h2});
      check({static_pred, dir_multiway}, 2'b10);
      fire_br(mkb(BHPA_SPTK, 5'b00000));
      check({dir_alloc, tac_wr_valid}, 2'b01);
      fire_br(mkb(BHPA_SPNT, 5'b00101));
      check({dir_alloc, tac_wr_valid, static_pred}, 3'b000);
      fire_br(mkb(BHPA_SPTK, 5'b10100));
      check({dir_alloc, force_taken, ret_push}, 3'b111);
      fire_br(mkb(BHPA_DPNT, 5'b00101));
      check(dir_alloc, 1'b1);
      fire_br(mkb(BHPA_DPNT, 5'b00000));
      check(dir_alloc, 1'b0);
      fire_br(mkb(BHPA_DPTK, 5'b01110));
      check({dir_alloc, tac_wr_valid, ret_pop}, 3'b101);
      b = mkb(BHPA_DPTK, 5'b10101);
      b.clr = 1'b1;
      fire_br(b);
      check({dir_alloc, dir_update, tac_wr_valid, ret_push}, 4'b0001);
      for (int i = 0; i < 6; i++)
      begin
         brp0 = mkp(bhpa_brp_kind_type'(i[2:0]), 32'h0000_4000 + i);
         step();
         brp0 = '0;
         check(tac_wr_valid, i < 3);
         if (i < 3) check({tac_wr.target, tac_wr.slot}, {32'h0000_4000 + i, TAC_SLOT_BRP});
      end
      brp0 = mkp(BHPA_BRP_SPTK, 32'h0000_4100);
      brp0.slot = 2'h1;
      step();
      // Hint goes out one cycle ahead of the first loop branch below
      brp0 = mkp(BHPA_BRP_LOOP, 32'h0000_4200);
      check(tac_wr_valid, 1'b0);
      brp0.imp = 1'b1;
      step();
      brp0 = '0;
      check({tac_wr_valid, tar_wr_valid, loop_exit_armed}, 3'b111);
      check({tar_wr.target, tar_wr.slot}, {32'h0000_4200, TAC_SLOT_BRP});
      epilogue_count = 8'h02;
      b = mkb(BHPA_DPTK, 5'b00110);
      b.is_cloop = 1'b1;
      fire_br(b);
      check(loop_exit_predict, 1'b0);
      epilogue_count = EC_LOOP_VAL;
      fire_br(b);
      check(loop_exit_predict, 1'b1);
      b.is_cloop = 1'b0;
      b.is_ctop = 1'b1;
      epilogue_count = 8'h05;
      fire_br(b);
      check(loop_exit_predict, 1'b1);
      mov_valid = 1'b1;
      mov_whether = BHPA_DPTK;
      step();
      mov_valid = 1'b0;
      for (n0 = 1; n0 < 20 && tac_wr_valid !== 1'b1; n0++)
         step();
      check(n0, MOV_L + 1);
      check(tac_wr.target, 32'h0000_7000);
      b = mkb(BHPA_DPTK, 5'b00010);
      b.pf = BHPA_PF_MANY;
      fire_br(b);
      wait_got(1);
      check(last_addr, 32'h0000_2040);
      wait_got(4);
      check(pf_busy, 1'b1);
      fire_br(mkb(BHPA_SPNT, 5'b00010));
      repeat (3) step();
      check(pf_busy, 1'b0);
      // Each prefetch-free variant must leave the cache untouched
      for (int i = 0; i < 3; i++)
      begin
         n0 = n_got;
         b.slot = (i == 0) ? 2'h1 : BRP_SLOT;
         b.pf = (i == 1) ? BHPA_PF_FEW : BHPA_PF_MANY;
         b.predicted_taken = (i == 2) ? 1'b0 : 1'b1;
         fire_br(b);
         repeat (4) step();
         check(n_got, n0);
      end
      n0 = n_got;
      brp0 = mkp(BHPA_BRP_SPTK, 32'h0000_5000);
      brp0.line_pf = 1'b1;
      step();
      brp0 = '0;
      repeat (8) step();
      check(n_got, n0 + LINE_PF_LINES);
      stall = 1'b1;
      drops = 0;
      for (int i = 0; i < 6; i++)
      begin
         brp0 = mkp(BHPA_BRP_SPTK, 32'h0000_8000 + 32'h40 * i);
         brp0.line_pf = 1'b1;
         brp1 = brp0;
         step();
         drops += pf_dropped;
      end
      brp0 = '0;
      brp1 = '0;
      check(pf_full, 1'b1);
      check(drops != 0, 1'b1);
      mispredict_flush = 1'b1;
      step();
      mispredict_flush = 1'b0;
      stall = 1'b0;
      check(pf_full, 1'b0);
      repeat (6) step();
      report_and_stop();
   end
endmodule
`default_nettype wire
